// *** inc/svcm_pkg.sv ***
package svcm_pkg;
	// system clock doubles as the recovered pixel clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PCLK_KHZ = 1000000000 / CLK_PERIOD_PS;
	// accepted pixel clock ranges per rate range select
	localparam int LO_RATE_MIN_KHZ = 6250;
	localparam int LO_RATE_MAX_KHZ = 16660;
	localparam int HI_RATE_MIN_KHZ = 12500;
	localparam int HI_RATE_MAX_KHZ = 104000;
	// output lane bit rate window
	localparam int LANE_MIN_MBPS = 80;
	localparam int LANE_MAX_MBPS = 1000;
	localparam int KHZ_PER_MHZ = 1000;
	// link word layout
	localparam int LINK_W = 27;
	localparam int PIX_W = 24;
	localparam int HS_BIT = 18;
	localparam int VS_BIT = 19;
	localparam int DE_BIT = 20;
	localparam int HI_BASE = 21;
	// special packet payload layout
	localparam int PKT_W = 7;
	localparam int PKT_HS_BIT = 4;
	localparam int PKT_VS_BIT = 5;
	localparam int PKT_DE_BIT = 6;
	localparam int DE_CNT_W = 16;
	// width mode select pin levels
	typedef enum logic [1:0] {
		SVCM_WMS_LOW,
		SVCM_WMS_MID,
		SVCM_WMS_OPEN,
		SVCM_WMS_HIGH
	} svcm_wms_e;
	// output data type
	typedef enum logic [2:0] {
		SVCM_RAW8,
		SVCM_RAW10,
		SVCM_RAW12,
		SVCM_RAW14,
		SVCM_USER8,
		SVCM_USER24
	} svcm_type_e;
	// serializer control sampling policy
	typedef enum logic [1:0] {
		SVCM_CT_DEFAULT,
		SVCM_CT_ALWAYS,
		SVCM_CT_SYNC,
		SVCM_CT_NEVER
	} svcm_ctrig_e;
endpackage : svcm_pkg

// *** inc/svcm_link_if.sv ***
`timescale 1ns/1ps
interface svcm_link_if;
	// parallel link word, packet marker, handshake and lock
	logic [svcm_pkg::LINK_W-1:0] word;
	logic pkt;
	logic valid;
	logic ready;
	logic lock;
	modport ser (output word, output pkt, output valid, output lock,
		input ready);
	modport des (input word, input pkt, input valid, input lock,
		output ready);
endinterface : svcm_link_if

// *** hw/svcm_fifo.sv ***
`timescale 1ns/1ps
module svcm_fifo #(
	parameter int W = 24,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import svcm_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} svcm_fifo_s;
	svcm_fifo_s st_reg;
	svcm_fifo_s st_next;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// extra pointer bit tells full from empty without a counter
	assign in_ready = (st_reg.wp[AW-1:0] != st_reg.rp[AW-1:0]) ||
		(st_reg.wp[AW] == st_reg.rp[AW]);
	assign out_valid = st_reg.wp != st_reg.rp;
	assign out_data = mem[st_reg.rp[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer advance
	always_comb begin
		st_next = st_reg;
		if (push) st_next.wp = st_reg.wp + 1'b1;
		if (pop) st_next.rp = st_reg.rp + 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) st_reg <= '0;
		else st_reg <= st_next;
	end

	// storage has no reset; only pointers define content
	always_ff @(posedge clk_sys) begin
		if (push) mem[st_reg.wp[AW-1:0]] <= in_data;
	end
endmodule : svcm_fifo

// *** hw/svcm_des_end.sv ***
`timescale 1ns/1ps
// Summary of operation
// R1: single-load pixel bit n from input n
// R2: RAW8/10/12 single-load unless pack select set; RAW14 always single-load
// R3: double-load emits A then B per word
// R4: wide types need width select high/open
// R5: rate select 1 accepts 6.25-16.66 MHz
// R6: rate select 0 accepts 12.5-104 MHz
// R7: lane rate must stay 80-1000 Mbps
// R8: lane rate is pclk times width over lanes
// R9: high-bandwidth mode when width select open
// R10: high-bandwidth syncs come from packets
// R11: sync packets replace pixel around edges
// R12: control packets replace pixel before change
// R13: sync low pulses last two pixels minimum
// R14: control sampled per data-enable state
// R15: serializer data-enable trigger setting
// R16: data-enable tracking off when enable low
// R17: lock loss stops clock lane at LP-11
// R18: width select picks 24, hb or 32 mode
// R19: unused input bits never reach pixels
// R20: control outputs hold last decoded value
module svcm_des_end #(
	parameter int FIFO_DEPTH = 4,
	parameter int CNT_W = svcm_pkg::DE_CNT_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	svcm_link_if.des link,
	input wire svcm_pkg::svcm_wms_e width_mode_select,
	input wire logic rate_range_select,
	input wire logic input_pack_select,
	input wire logic de_track_enable,
	input wire svcm_pkg::svcm_type_e out_type,
	input wire logic [1:0] lane_count,
	output logic [svcm_pkg::PIX_W-1:0] pix_word,
	output logic pix_valid,
	input wire logic pix_ready,
	output logic horizontal_sync,
	output logic vertical_sync,
	output logic data_enable,
	output logic [3:0] aux_control_outputs,
	output logic hb_mode,
	output logic lane_rate_ok,
	output logic pclk_range_ok,
	output logic mode_err,
	output logic de_period_err,
	output logic clk_lane_hs_en,
	output logic clk_lane_stop
);
	import svcm_pkg::*;
	typedef struct packed {
		logic hs;
		logic vs;
		logic de;
		logic [3:0] ctrl;
		logic pv;
		logic [PIX_W-1:0] pd;
		logic bv;
		logic [PIX_W-1:0] bd;
		logic [CNT_W-1:0] de_cnt;
		logic [CNT_W-1:0] de_per;
		logic de_err;
		logic hb;
		logic rate_ok;
		logic clk_ok;
		logic mode_err;
		logic hs_en;
		logic stop;
	} svcm_des_s;
	svcm_des_s st_reg;
	svcm_des_s st_next;
	logic f_in_rdy;
	logic [LINK_W-1:0] w;
	logic hb;
	logic dbl;
	logic wide;
	logic bad;
	logic take;
	logic de_now;
	logic [PIX_W-1:0] pa;
	logic [PIX_W-1:0] pb;
	logic has_b;
	int bits;
	int lanes;
	int load;

	assign w = link.word;
	// width select mid or open selects the high-bandwidth format
	assign hb = (width_mode_select == SVCM_WMS_MID) ||
		(width_mode_select == SVCM_WMS_OPEN); // R18 R9
	// only RAW 8/10/12 pack two pixels per word
	assign dbl = input_pack_select && (out_type == SVCM_RAW8 ||
		out_type == SVCM_RAW10 || out_type == SVCM_RAW12); // R2
	assign wide = (dbl && out_type != SVCM_RAW8) ||
		(out_type == SVCM_USER24);
	assign bad = wide && !(width_mode_select == SVCM_WMS_HIGH ||
		width_mode_select == SVCM_WMS_OPEN); // R4
	// the B half blocks the link so a packed word costs two cycles
	assign link.ready = link.lock && !st_reg.bv &&
		(!st_reg.pv || f_in_rdy);
	assign take = link.valid && link.ready;

	// pixel mapping; unmapped positions stay zero
	always_comb begin
		pa = '0;
		pb = '0;
		has_b = 1'b0;
		bits = 8;
		case (out_type)
		SVCM_RAW8: begin
			if (dbl) begin
				pa[7:0] = w[7:0]; // R3
				pb[7:0] = w[15:8]; // R3
				has_b = 1'b1;
				bits = 16;
			end else begin
				pa[7:0] = w[7:0]; // R1 R19
			end
		end
		SVCM_RAW10: begin
			if (dbl) begin
				pa[9:0] = w[9:0]; // R3
				pb[9:0] = {w[HI_BASE+1:HI_BASE], w[17:10]}; // R3
				has_b = 1'b1;
				bits = 20;
			end else begin
				pa[9:0] = w[9:0]; // R1 R19
				bits = 10;
			end
		end
		SVCM_RAW12: begin
			if (dbl) begin
				pa[11:0] = w[11:0]; // R3
				pb[11:0] = {w[HI_BASE+5:HI_BASE], w[17:12]}; // R3
				has_b = 1'b1;
				bits = 24;
			end else begin
				pa[11:0] = w[11:0]; // R1 R19
				bits = 12;
			end
		end
		SVCM_RAW14: begin
			pa[13:0] = w[13:0]; // R1 R19
			bits = 14;
		end
		SVCM_USER8: begin
			pa[7:0] = w[7:0]; // R1 R19
		end
		SVCM_USER24: begin
			// bytes C, B, A packed high to low in one word
			pa = {w[26:25], w[17:12], w[24:23], w[11:6],
				w[22:21], w[5:0]}; // R4
			bits = 24;
		end
		default: begin
			pa = '0;
		end
		endcase
	end

	// lane count and lane load for the lane rate check
	always_comb begin
		lanes = int'(lane_count) + 1;
		load = PCLK_KHZ * bits; // R8
	end

	// next state
	always_comb begin
		st_next = st_reg;
		de_now = st_reg.de;
		st_next.hb = hb;
		st_next.mode_err = bad;
		st_next.rate_ok = (load >= LANE_MIN_MBPS * KHZ_PER_MHZ * lanes) &&
			(load <= LANE_MAX_MBPS * KHZ_PER_MHZ * lanes); // R7 R8
		if (rate_range_select) begin
			st_next.clk_ok = (PCLK_KHZ >= LO_RATE_MIN_KHZ) &&
				(PCLK_KHZ <= LO_RATE_MAX_KHZ); // R5
		end else begin
			st_next.clk_ok = (PCLK_KHZ >= HI_RATE_MIN_KHZ) &&
				(PCLK_KHZ <= HI_RATE_MAX_KHZ); // R6
		end
		if (st_reg.pv && f_in_rdy) st_next.pv = 1'b0;
		if (take) begin
			if (hb && link.pkt) begin
				// packet stands in for a pixel; nothing is emitted
				st_next.hs = w[PKT_HS_BIT]; // R10
				st_next.vs = w[PKT_VS_BIT]; // R10
				st_next.de = w[PKT_DE_BIT]; // R10
				st_next.ctrl = w[3:0]; // R10 R20
			end else begin
				if (!hb) begin
					st_next.hs = w[HS_BIT]; // R1
					st_next.vs = w[VS_BIT]; // R1
					st_next.de = w[DE_BIT]; // R1
				end
				de_now = st_next.de;
				// misconfigured wide types drop pixels, not garble them
				if (de_now && !bad) begin
					st_next.pv = 1'b1;
					st_next.pd = pa;
					st_next.bv = has_b; // R3
					st_next.bd = pb;
				end
			end
			// period between data-enable rises, one count per word
			st_next.de_cnt = st_reg.de_cnt + 1'b1;
			if (st_next.de && !st_reg.de) begin
				if (st_reg.de_per != '0 && st_reg.de_per != st_reg.de_cnt)
					st_next.de_err = 1'b1;
				st_next.de_per = st_reg.de_cnt;
				st_next.de_cnt = '0;
			end
		end else if (st_reg.bv && (!st_reg.pv || f_in_rdy)) begin
			st_next.pv = 1'b1; // R3
			st_next.pd = st_reg.bd;
			st_next.bv = 1'b0;
		end
		if (!de_track_enable) begin
			st_next.de_cnt = '0; // R16
			st_next.de_per = '0; // R16
			st_next.de_err = 1'b0; // R16
		end
		// without lock the clock lane parks in the stop state
		st_next.hs_en = link.lock; // R17
		st_next.stop = !link.lock; // R17
		if (!link.lock) begin
			st_next.pv = 1'b0;
			st_next.bv = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.stop <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// four-word elastic store between mapper and output user
	svcm_fifo #(
		.W(PIX_W),
		.DEPTH(FIFO_DEPTH)
	) svcm_fifo_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(st_reg.pv),
		.in_ready(f_in_rdy),
		.in_data(st_reg.pd),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(pix_word)
	);

	assign horizontal_sync = st_reg.hs;
	assign vertical_sync = st_reg.vs;
	assign data_enable = st_reg.de;
	assign aux_control_outputs = st_reg.ctrl;
	assign hb_mode = st_reg.hb;
	assign lane_rate_ok = st_reg.rate_ok;
	assign pclk_range_ok = st_reg.clk_ok;
	assign mode_err = st_reg.mode_err;
	assign de_period_err = st_reg.de_err;
	assign clk_lane_hs_en = st_reg.hs_en;
	assign clk_lane_stop = st_reg.stop;
endmodule : svcm_des_end

// *** hw/svcm_ser_end.sv ***
`timescale 1ns/1ps
module svcm_ser_end (
	input wire logic clk_sys,
	input wire logic sys_rst,
	svcm_link_if.ser link,
	input wire svcm_pkg::svcm_wms_e width_mode_select,
	input wire logic de_trigger_disable,
	input wire svcm_pkg::svcm_ctrig_e control_trigger_select,
	input wire logic link_up,
	input wire logic [svcm_pkg::LINK_W-1:0] pix_in,
	input wire logic horizontal_sync,
	input wire logic vertical_sync,
	input wire logic data_enable,
	input wire logic [3:0] aux_control_outputs,
	input wire logic pix_in_valid,
	output logic pix_in_ready
);
	import svcm_pkg::*;
	typedef struct packed {
		logic sv;
		logic [LINK_W-1:0] sw;
		logic shs;
		logic svs;
		logic sde;
		logic srepl;
		logic [PKT_W-1:0] spay;
		logic [3:0] csamp;
		logic ov;
		logic opkt;
		logic [LINK_W-1:0] ow;
		logic lock;
	} svcm_ser_s;
	svcm_ser_s st_reg;
	svcm_ser_s st_next;
	logic hb;
	logic adv;
	logic take;
	logic samp_en;
	logic rise;
	logic fall;
	logic chg;
	logic repl;
	logic [3:0] samp;
	logic [PKT_W-1:0] pay;

	assign hb = (width_mode_select == SVCM_WMS_MID) ||
		(width_mode_select == SVCM_WMS_OPEN); // R9
	assign adv = !st_reg.ov || link.ready;
	assign pix_in_ready = adv;
	assign take = pix_in_valid && adv;

	// one pixel of lookahead lets a packet replace the pixel before an edge
	always_comb begin
		st_next = st_reg;
		st_next.lock = link_up;
		case (control_trigger_select)
		SVCM_CT_ALWAYS: samp_en = 1'b1;
		SVCM_CT_SYNC: samp_en = (horizontal_sync != st_reg.shs) ||
			(vertical_sync != st_reg.svs);
		SVCM_CT_NEVER: samp_en = 1'b0;
		default: samp_en = !data_enable ||
			(horizontal_sync != st_reg.shs) ||
			(vertical_sync != st_reg.svs); // R14
		endcase
		samp = samp_en ? aux_control_outputs : st_reg.csamp; // R14
		// data-enable edges trigger packets only with the trigger set
		rise = (!st_reg.shs && horizontal_sync) ||
			(!st_reg.svs && vertical_sync) ||
			(de_trigger_disable && !st_reg.sde && data_enable); // R11 R15
		fall = (st_reg.shs && !horizontal_sync) ||
			(st_reg.svs && !vertical_sync) ||
			(de_trigger_disable && st_reg.sde && !data_enable); // R11 R15
		chg = samp != st_reg.csamp; // R12
		repl = st_reg.srepl || (hb && (rise || chg)); // R11 R12
		pay = (rise || chg) ?
			{data_enable, vertical_sync, horizontal_sync, samp} :
			st_reg.spay;
		if (st_reg.ov && link.ready) st_next.ov = 1'b0;
		if (take) begin
			if (st_reg.sv) begin
				st_next.ov = 1'b1;
				st_next.opkt = repl;
				st_next.ow = repl ? {{(LINK_W-PKT_W){1'b0}}, pay} : st_reg.sw;
			end
			st_next.sv = 1'b1;
			st_next.sw = pix_in;
			if (!hb) begin
				st_next.sw[HS_BIT] = horizontal_sync;
				st_next.sw[VS_BIT] = vertical_sync;
				st_next.sw[DE_BIT] = data_enable;
			end
			st_next.shs = horizontal_sync;
			st_next.svs = vertical_sync;
			st_next.sde = data_enable;
			// the pixel after a falling edge is the one replaced
			st_next.srepl = hb && st_reg.sv && fall; // R11
			st_next.spay = {data_enable, vertical_sync, horizontal_sync,
				samp};
			st_next.csamp = samp;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) st_reg <= '0;
		else st_reg <= st_next;
	end

	assign link.word = st_reg.ow;
	assign link.pkt = st_reg.opkt;
	assign link.valid = st_reg.ov;
	assign link.lock = st_reg.lock;
endmodule : svcm_ser_end

// *** bench/svcm_properties.sv ***
`timescale 1ns/1ps
module svcm_properties
	import svcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [LINK_W-1:0] word,
	input wire logic pkt,
	input wire logic valid,
	input wire logic ready,
	input wire logic lock,
	input wire svcm_wms_e width_mode_select,
	input wire logic hb_mode,
	input wire logic horizontal_sync,
	input wire logic vertical_sync,
	input wire logic data_enable,
	input wire logic [3:0] aux_control_outputs,
	input wire logic clk_lane_stop,
	input wire logic clk_lane_hs_en
);
	// one clock domain, so one clocking and one reset for all
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic tk = valid && ready;
	wire logic [2:0] syn = {horizontal_sync, vertical_sync, data_enable};
	// a stalled word must not change under the receiver
	AST_HOLD: assert property (valid && !ready |=> valid && $stable(word)
		&& $stable(pkt)) else $error("link word changed while stalled");
	AST_READY_LOCK: assert property (!lock |-> !ready)
		else $error("ready while unlocked");
	AST_LANE_STOP: assert property (!lock |=> clk_lane_stop
		&& !clk_lane_hs_en) else $error("clock lane not stopped");
	AST_MODE_LOW: assert property (width_mode_select == SVCM_WMS_LOW
		|=> !hb_mode) else $error("hb mode with low width select");
	AST_MODE_OPEN: assert property (width_mode_select == SVCM_WMS_OPEN
		|=> hb_mode) else $error("hb mode missing with open select");
	AST_NO_PKT: assert property (!hb_mode |-> !(valid && pkt))
		else $error("packet outside hb mode");
	// the de bit comes straight from the word when not in hb mode
	AST_SYNC_BITS: assert property (tk && !hb_mode |=>
		data_enable == $past(word[DE_BIT])) else $error("de bit lost");
	AST_HB_HOLD: assert property (hb_mode && !(tk && pkt) |=>
		$stable(syn)) else $error("sync moved without packet");
	AST_CTRL_HOLD: assert property (!(tk && pkt) |=>
		$stable(aux_control_outputs)) else $error("control moved");
endmodule : svcm_properties

// *** bench/serial_video_to_csi_mapper_test.sv ***
`timescale 1ns/1ps
module serial_video_to_csi_mapper_test;
	import svcm_pkg::*;
	logic clk_sys = 0, sys_rst = 1, lu = 0, piv = 0, prdy = 1;
	logic dtd = 0, rrs = 0, ips = 0, dte = 0, hs = 0, vs = 0, de = 0;
	logic [1:0] lc = 0;
	logic [3:0] aux = 0, daux;
	logic [26:0] pin = 0;
	logic [23:0] pw;
	logic pv, pir, dhs, dvs, dde, hb, lok, pok, merr, derr, hsen, stop;
	svcm_wms_e wms = SVCM_WMS_LOW;
	svcm_type_e ot = SVCM_RAW8;
	svcm_ctrig_e cts = SVCM_CT_DEFAULT;
	logic [23:0] got[$];
	int n_errors = 0, n_tests = 0, cyc = 0;
	svcm_link_if link_i();
	svcm_ser_end svcm_ser_end_i(.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link_i.ser), .width_mode_select(wms),
		.de_trigger_disable(dtd), .control_trigger_select(cts),
		.link_up(lu), .pix_in(pin), .horizontal_sync(hs),
		.vertical_sync(vs), .data_enable(de), .aux_control_outputs(aux),
		.pix_in_valid(piv), .pix_in_ready(pir));
	svcm_des_end svcm_des_end_i(.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link_i.des), .width_mode_select(wms),
		.rate_range_select(rrs), .input_pack_select(ips),
		.de_track_enable(dte), .out_type(ot), .lane_count(lc),
		.pix_word(pw), .pix_valid(pv), .pix_ready(prdy),
		.horizontal_sync(dhs), .vertical_sync(dvs), .data_enable(dde),
		.aux_control_outputs(daux), .hb_mode(hb), .lane_rate_ok(lok),
		.pclk_range_ok(pok), .mode_err(merr), .de_period_err(derr),
		.clk_lane_hs_en(hsen), .clk_lane_stop(stop));
	svcm_properties svcm_properties_i(.clk_sys(clk_sys), .sys_rst(sys_rst),
		.word(link_i.word), .pkt(link_i.pkt), .valid(link_i.valid),
		.ready(link_i.ready), .lock(link_i.lock), .width_mode_select(wms),
		.hb_mode(hb), .horizontal_sync(dhs), .vertical_sync(dvs),
		.data_enable(dde), .aux_control_outputs(daux),
		.clk_lane_stop(stop), .clk_lane_hs_en(hsen));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// collect every pixel handed over at the output
	always @(posedge clk_sys) begin
		if (pv === 1'b1 && prdy) got.push_back(pw);
	end
	// a hang counts as a mismatch and still ends in the verdict
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop;
		end
	end
	task report_and_stop;
		if (n_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	task step;
		@(posedge clk_sys);
		#1;
	endtask : step
	task chk(input logic [23:0] s, input logic [23:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task take_pix(input logic [23:0] e);
		logic [23:0] s;
		s = got.size() ? got.pop_front() : 'x;
		chk(s, e);
	endtask : take_pix
	// width, type and pack pins are only moved under reset so both ends agree
	task cfg(input svcm_wms_e w, input svcm_type_e t, input logic p);
		wms = w;
		ot = t;
		ips = p;
		sys_rst = 1;
		repeat (2) step;
		sys_rst = 0;
		repeat (3) step;
		got.delete();
	endtask : cfg
	// held until the serializer takes it; the caller drops valid
	task send(input logic [26:0] w, input logic [2:0] s);
		pin = w;
		{de, vs, hs} = s;
		piv = 1;
		while (!pir) step;
		step;
	endtask : send
	// a trailing blank word pushes the lookahead pixel out
	task fin;
		send(27'h0, 3'b000);
		piv = 0;
		repeat (8) step;
	endtask : fin
	task t_single;
		svcm_type_e ty[5] = '{SVCM_RAW8, SVCM_RAW10, SVCM_RAW12,
			SVCM_RAW14, SVCM_USER8};
		int wd[5] = '{8, 10, 12, 14, 8};
		for (int i = 0; i < 5; i++) begin
			cfg(SVCM_WMS_LOW, ty[i], 0);
			send(27'h7ff5a5c, 3'b100);
			fin;
			take_pix(27'h7ff5a5c & ((27'h1 << wd[i]) - 1));
			chk(got.size(), 0);
		end
	endtask : t_single
	task t_double;
		logic [26:0] w = 27'h5a3c96b;
		cfg(SVCM_WMS_HIGH, SVCM_RAW8, 1);
		send(w, 3'b100);
		fin;
		take_pix(w[7:0]);
		take_pix(w[15:8]);
		cfg(SVCM_WMS_HIGH, SVCM_RAW10, 1);
		send(w, 3'b100);
		fin;
		take_pix(w[9:0]);
		take_pix({w[22:21], w[17:10]});
		cfg(SVCM_WMS_HIGH, SVCM_RAW12, 1);
		send(w, 3'b100);
		fin;
		take_pix(w[11:0]);
		take_pix({w[26:21], w[17:12]});
	endtask : t_double
	task t_user24;
		logic [26:0] w = 27'h5a3c96b;
		cfg(SVCM_WMS_HIGH, SVCM_USER24, 0);
		send(w, 3'b100);
		fin;
		take_pix(24'hbce56b);
		chk(merr, 0);
		// low select refuses the wide type; de still rides in bit 20 here
		cfg(SVCM_WMS_LOW, SVCM_USER24, 0);
		send(w, 3'b100);
		fin;
		chk(got.size(), 0);
		chk(merr, 1);
	endtask : t_user24
	task t_rate;
		cfg(SVCM_WMS_LOW, SVCM_RAW8, 0);
		lc = 3;
		rrs = 1;
		repeat (2) step;
		chk(pok, PCLK_KHZ >= LO_RATE_MIN_KHZ &&
			PCLK_KHZ <= LO_RATE_MAX_KHZ);
		chk(lok, PCLK_KHZ * 8 >= LANE_MIN_MBPS * KHZ_PER_MHZ * 4);
		rrs = 0;
		lc = 0;
		repeat (2) step;
		chk(pok, PCLK_KHZ >= HI_RATE_MIN_KHZ &&
			PCLK_KHZ <= HI_RATE_MAX_KHZ);
		chk(lok, PCLK_KHZ * 8 <= LANE_MAX_MBPS * KHZ_PER_MHZ);
	endtask : t_rate
	task t_hb;
		cfg(SVCM_WMS_OPEN, SVCM_RAW8, 0);
		repeat (2) send(27'h11, 3'b000);
		aux = 4'h5;
		repeat (2) send(27'h22, 3'b000);
		repeat (3) send(27'h33, 3'b101);
		aux = 4'ha;
		repeat (3) send(27'h44, 3'b101);
		piv = 0;
		repeat (4) step;
		chk(dhs, 1);
		chk(daux, 4'h5);
		repeat (3) send(27'h55, 3'b100);
		fin;
		chk(dhs, 0);
		chk(daux, 4'ha);
	endtask : t_hb
	// de edges make packets only with the trigger set; sampling is off so
	// a new control value must never leak into a packet
	task t_detrig;
		cfg(SVCM_WMS_OPEN, SVCM_RAW8, 0);
		dtd = 1;
		cts = SVCM_CT_NEVER;
		aux = 4'h3;
		repeat (2) send(27'h11, 3'b000);
		repeat (2) send(27'h66, 3'b100);
		repeat (2) send(27'h77, 3'b000);
		fin;
		dtd = 0;
		cts = SVCM_CT_DEFAULT;
		chk(dde, 0);
		chk(daux, 4'h0);
		take_pix(24'h66);
		take_pix(24'h66);
		chk(got.size(), 0);
	endtask : t_detrig
	task t_lock;
		cfg(SVCM_WMS_LOW, SVCM_RAW8, 0);
		chk({stop, hsen}, 2'b01);
		lu = 0;
		repeat (3) step;
		chk({stop, hsen}, 2'b10);
		lu = 1;
		repeat (3) step;
	endtask : t_lock
	task t_fifo;
		cfg(SVCM_WMS_LOW, SVCM_RAW8, 0);
		prdy = 0;
		fork
			begin
				for (int i = 1; i < 13; i++) send(i, 3'b100);
				fin;
			end
			begin
				repeat (40) step;
				chk({pir, pv}, 2'b01);
				prdy = 1;
			end
		join
		for (int i = 1; i < 13; i++) take_pix(i);
	endtask : t_fifo
	task t_track;
		int hi[4] = '{3, 3, 3, 2};
		cfg(SVCM_WMS_LOW, SVCM_RAW8, 0);
		dte = 1;
		for (int i = 0; i < 4; i++) begin
			repeat (hi[i]) send(27'h1, 3'b100);
			send(27'h0, 3'b000);
			if (i == 2) chk(derr, 0);
		end
		send(27'h1, 3'b100);
		fin;
		chk(derr, 1);
		dte = 0;
		repeat (2) step;
		chk(derr, 0);
	endtask : t_track
	initial begin
		repeat (12) step;
		sys_rst = 0;
		lu = 1;
		// let an edge pass so the first cfg does not hit reset twice at once
		step;
		t_single;
		t_double;
		t_user24;
		t_rate;
		t_hb;
		t_detrig;
		t_lock;
		t_fifo;
		t_track;
		report_and_stop;
	end
endmodule : serial_video_to_csi_mapper_test
